// ===== pkg/pin_event_pkg.sv
// shared constants for the pin event interrupt logic
package pin_event_pkg;
    localparam int NUM_PINS     = 64;
    localparam int SEL_W        = 6;
    localparam int NUM_CHAN     = 8;
    localparam int NUM_GROUPS   = 2;
    localparam int SYNC_STAGES  = 2;
    localparam logic [SEL_W-1:0] SEL_RESET = 6'h00;
    // pattern term source modes
    localparam logic [2:0] PM_ALWAYS  = 3'h0;
    localparam logic [2:0] PM_HIGH    = 3'h1;
    localparam logic [2:0] PM_LOW     = 3'h2;
    localparam logic [2:0] PM_RISE    = 3'h3;
    localparam logic [2:0] PM_FALL    = 3'h4;
    localparam logic [2:0] PM_ANYEDGE = 3'h5;
    localparam logic [2:0] PM_NEVER   = 3'h6;
endpackage

// ===== rtl/group_irq_block.sv
// one grouped interrupt block: or/and of enabled polarity-adjusted pins
module group_irq_block
(
    input  wire logic                                clk_sys_in,
    input  wire logic                                reset_in,
    input  wire logic [pin_event_pkg::NUM_PINS-1:0]  pins_raw_in,
    input  wire logic [pin_event_pkg::NUM_PINS-1:0]  pins_sync_in,
    input  wire logic [pin_event_pkg::NUM_PINS-1:0]  enable_in,
    input  wire logic [pin_event_pkg::NUM_PINS-1:0]  polarity_high_in,
    input  wire logic                                combine_and_in,
    input  wire logic                                edge_mode_in,
    input  wire logic                                status_clear_in,
    output logic                                     wake_out,
    output logic                                     irq_out,
    output logic                                     status_out
);
    import pin_event_pkg::*;

    typedef struct packed
    {
        logic match_prev;
        logic status;
    } grp_state_t;

    grp_state_t s_q;
    grp_state_t s_d;
    logic       match_now;

    function automatic logic combine(input logic [NUM_PINS-1:0] lv,
                                     input logic [NUM_PINS-1:0] en,
                                     input logic [NUM_PINS-1:0] pol,
                                     input logic                and_mode);
        logic [NUM_PINS-1:0] act;
        act = ~(lv ^ pol) & en;
        if (and_mode)
            return (en != '0) && ((act | ~en) == '1);
        return act != '0;
    endfunction

    assign match_now = combine(pins_sync_in, enable_in, polarity_high_in, combine_and_in);

    // asynchronous wake path on the raw pins, ahead of the synchronised request
    assign wake_out = combine(pins_raw_in, enable_in, polarity_high_in, combine_and_in);

    always_comb
    begin
        s_d            = s_q;
        s_d.match_prev = match_now;
        if (status_clear_in)
            s_d.status = 1'b0;
        if (edge_mode_in ? (match_now && !s_q.match_prev) : match_now)
            s_d.status = 1'b1;
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign irq_out    = s_q.status;
    assign status_out = s_q.status;

    a_grp_clear_set: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (status_clear_in && !match_now) |=> !status_out)
        else $error("group status not cleared");
    a_grp_edge_set: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (edge_mode_in && match_now && !s_q.match_prev) |=> status_out)
        else $error("group edge not latched");
    a_grp_level_hold: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (!edge_mode_in && match_now) |=> irq_out)
        else $error("group level request missing");
endmodule

// ===== rtl/pin_event_interrupt_logic.sv
// pin interrupt channels, pattern match engine and two grouped interrupt blocks
// Summary of operation
// - eight channels pick any pin, each edge or level sensitive; two pins excluded
// - each pin channel drives its own interrupt request line
// - edge channels trigger on rising, falling or both edges
// - level channels are active high or active low
// - pin channels raise wake-up requests for sleep and power-down modes
// - pattern engine evaluates levels and transitions of eight selected pins
// - every product term can raise its own interrupt request
// - a pattern match while no term request is active may optionally pulse the cpu event input
// - pattern matches never produce wake-up requests
// - pin selection comes from system configuration block settings
// - control settings are single-cycle ports, read and written directly
// - two independent grouped blocks each produce their own interrupt
// - grouped blocks hold a per-pin enable
// - each enabled grouped pin has its own polarity
// - grouped output is level or edge triggered by setting
// - grouped inputs combine by or or and
// - grouped blocks wake asynchronously before raising the request
// - writing one to grouped status clears its request, unless a level match or a new edge sets it again in that cycle
// - grouped blocks wake the part from sleep and power-down modes
module pin_event_interrupt_logic
    import pin_event_pkg::*;
(
    input  wire logic                            clk_sys_in,
    input  wire logic                            reset_in,
    input  wire logic [pin_event_pkg::NUM_PINS-1:0] pins_in,
    input  wire logic [pin_event_pkg::NUM_PINS-1:0] pin_excluded_in,
    input  wire logic [pin_event_pkg::NUM_CHAN*pin_event_pkg::SEL_W-1:0] chan_sel_in,
    input  wire logic                            sel_load_in,
    input  wire logic [pin_event_pkg::NUM_CHAN-1:0] chan_level_mode_in,
    input  wire logic [pin_event_pkg::NUM_CHAN-1:0] chan_rise_en_in,
    input  wire logic [pin_event_pkg::NUM_CHAN-1:0] chan_fall_en_in,
    input  wire logic [pin_event_pkg::NUM_CHAN-1:0] chan_level_high_in,
    input  wire logic [pin_event_pkg::NUM_CHAN-1:0] chan_enable_in,
    input  wire logic [pin_event_pkg::NUM_CHAN-1:0] chan_clear_in,
    input  wire logic                            pm_enable_in,
    input  wire logic [pin_event_pkg::NUM_CHAN*3-1:0] pm_src_mode_in,
    input  wire logic [pin_event_pkg::NUM_CHAN-1:0] pm_term_end_in,
    input  wire logic                            pm_event_en_in,
    input  wire logic [pin_event_pkg::NUM_PINS-1:0] grp_a_enable_in,
    input  wire logic [pin_event_pkg::NUM_PINS-1:0] grp_a_pol_high_in,
    input  wire logic                            grp_a_and_in,
    input  wire logic                            grp_a_edge_in,
    input  wire logic                            grp_a_clear_in,
    input  wire logic [pin_event_pkg::NUM_PINS-1:0] grp_b_enable_in,
    input  wire logic [pin_event_pkg::NUM_PINS-1:0] grp_b_pol_high_in,
    input  wire logic                            grp_b_and_in,
    input  wire logic                            grp_b_edge_in,
    input  wire logic                            grp_b_clear_in,
    output logic [pin_event_pkg::NUM_CHAN-1:0]   pin_irq_out,
    output logic [pin_event_pkg::NUM_CHAN-1:0]   chan_status_out,
    output logic [pin_event_pkg::NUM_CHAN-1:0]   pm_irq_out,
    output logic                                 cpu_event_notify_out,
    output logic                                 pin_wake_out,
    output logic                                 group_irq_block_a_out,
    output logic                                 group_irq_block_b_out,
    output logic                                 group_irq_block_a_wake_out,
    output logic                                 group_irq_block_b_wake_out,
    output logic                                 group_a_status_out,
    output logic                                 group_b_status_out
);
    import pin_event_pkg::*;

    typedef struct packed
    {
        logic [NUM_PINS-1:0]       sync1;
        logic [NUM_PINS-1:0]       sync2;
        logic [NUM_CHAN*SEL_W-1:0] sel;
        logic [NUM_CHAN-1:0]       chan_prev;
        logic [NUM_CHAN-1:0]       edge_flag;
        logic [NUM_CHAN-1:0]       irq;
        logic [NUM_CHAN-1:0]       pm_irq;
        logic                      event_pulse;
    } pie_state_t;

    pie_state_t s_q;
    pie_state_t s_d;

    logic [NUM_CHAN-1:0] chan_val;
    logic [NUM_CHAN-1:0] chan_rise;
    logic [NUM_CHAN-1:0] chan_fall;
    logic [NUM_CHAN-1:0] slice_true;
    logic [NUM_CHAN-1:0] term_hit;

    // one pattern slice: its level or transition condition on its channel
    function automatic logic slice_eval(input logic [2:0] mode,
                                        input logic       lv,
                                        input logic       rise,
                                        input logic       fall);
        unique case (mode)
            PM_ALWAYS:  return 1'b1;
            PM_HIGH:    return lv;
            PM_LOW:     return !lv;
            PM_RISE:    return rise;
            PM_FALL:    return fall;
            PM_ANYEDGE: return rise | fall;
            default:    return 1'b0;
        endcase
    endfunction

    genvar g;
    generate
        for (g = 0; g < NUM_CHAN; g++)
        begin : g_chan
            logic [SEL_W-1:0] sel_idx;
            assign sel_idx       = s_q.sel[g*SEL_W +: SEL_W];
            assign chan_val[g]   = s_q.sync2[sel_idx];
            assign chan_rise[g]  = chan_val[g] && !s_q.chan_prev[g];
            assign chan_fall[g]  = !chan_val[g] && s_q.chan_prev[g];
            assign slice_true[g] = slice_eval(pm_src_mode_in[g*3 +: 3], chan_val[g],
                                              chan_rise[g], chan_fall[g]);
        end
    endgenerate

    // product terms: consecutive slices up to an end mark form one term
    always_comb
    begin
        logic acc;
        acc      = 1'b1;
        term_hit = '0;
        for (int i = 0; i < NUM_CHAN; i++)
        begin
            acc = acc & slice_true[i];
            if (pm_term_end_in[i])
            begin
                term_hit[i] = acc;
                acc         = 1'b1;
            end
        end
    end

    always_comb
    begin
        logic [SEL_W-1:0] nsel;
        nsel           = '0;
        s_d            = s_q;
        s_d.sync1      = pins_in;
        s_d.sync2      = s_q.sync1;
        s_d.chan_prev  = chan_val;
        s_d.event_pulse = 1'b0;
        if (sel_load_in)
        begin
            for (int i = 0; i < NUM_CHAN; i++)
            begin
                nsel = chan_sel_in[i*SEL_W +: SEL_W];
                if (!pin_excluded_in[nsel])
                    s_d.sel[i*SEL_W +: SEL_W] = nsel;
            end
        end
        for (int i = 0; i < NUM_CHAN; i++)
        begin
            if (chan_clear_in[i])
                s_d.edge_flag[i] = 1'b0;
            if (!pm_enable_in && chan_enable_in[i] && !chan_level_mode_in[i]
                && ((chan_rise_en_in[i] && chan_rise[i]) || (chan_fall_en_in[i] && chan_fall[i])))
                s_d.edge_flag[i] = 1'b1;
            if (chan_level_mode_in[i])
                s_d.irq[i] = !pm_enable_in && chan_enable_in[i]
                             && (chan_val[i] == chan_level_high_in[i]);
            else
                s_d.irq[i] = !pm_enable_in && s_d.edge_flag[i];
        end
        s_d.pm_irq = pm_enable_in ? term_hit : '0;
        if (pm_enable_in && pm_event_en_in && (term_hit != '0) && (s_q.pm_irq == '0))
            s_d.event_pulse = 1'b1;
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
        begin
            s_q     <= '0;
            s_q.sel <= {NUM_CHAN{SEL_RESET}};
        end
        else
            s_q <= s_d;
    end

    assign pin_irq_out          = s_q.irq;
    assign chan_status_out      = s_q.edge_flag;
    assign pm_irq_out           = s_q.pm_irq;
    assign cpu_event_notify_out = s_q.event_pulse;
    assign pin_wake_out         = |s_q.irq;

    group_irq_block u_grp_a
    (
        .clk_sys_in       (clk_sys_in),
        .reset_in         (reset_in),
        .pins_raw_in      (pins_in),
        .pins_sync_in     (s_q.sync2),
        .enable_in        (grp_a_enable_in),
        .polarity_high_in (grp_a_pol_high_in),
        .combine_and_in   (grp_a_and_in),
        .edge_mode_in     (grp_a_edge_in),
        .status_clear_in  (grp_a_clear_in),
        .wake_out         (group_irq_block_a_wake_out),
        .irq_out          (group_irq_block_a_out),
        .status_out       (group_a_status_out)
    );

    group_irq_block u_grp_b
    (
        .clk_sys_in       (clk_sys_in),
        .reset_in         (reset_in),
        .pins_raw_in      (pins_in),
        .pins_sync_in     (s_q.sync2),
        .enable_in        (grp_b_enable_in),
        .polarity_high_in (grp_b_pol_high_in),
        .combine_and_in   (grp_b_and_in),
        .edge_mode_in     (grp_b_edge_in),
        .status_clear_in  (grp_b_clear_in),
        .wake_out         (group_irq_block_b_wake_out),
        .irq_out          (group_irq_block_b_out),
        .status_out       (group_b_status_out)
    );

    sequence s_rise_seen(int ch);
        !chan_val[ch] ##1 chan_val[ch];
    endsequence

    a_edge_rise_irq: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (!pm_enable_in && chan_enable_in[0] && !chan_level_mode_in[0] && chan_rise_en_in[0]
         && !chan_clear_in[0] && chan_rise[0]) |=> pin_irq_out[0])
        else $error("rising edge did not raise channel 0");

    a_fall_edge_irq: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (!pm_enable_in && chan_enable_in[1] && !chan_level_mode_in[1] && chan_fall_en_in[1]
         && chan_fall[1]) |=> pin_irq_out[1])
        else $error("falling edge did not raise channel 1");

    a_flag_clear: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (chan_clear_in[2] && !chan_rise[2] && !chan_fall[2]) |=> !chan_status_out[2])
        else $error("edge flag of channel 2 not cleared");

    a_flag_sticky: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (chan_status_out[1] && !chan_clear_in[1]) |=> chan_status_out[1])
        else $error("edge flag of channel 1 lost");

    a_level_follow: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (!pm_enable_in && chan_enable_in[4] && chan_level_mode_in[4]
         && chan_val[4] == chan_level_high_in[4]) |=> pin_irq_out[4])
        else $error("level channel 4 not active");

    a_level_idle: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (chan_level_mode_in[4] && chan_val[4] != chan_level_high_in[4]) |=> !pin_irq_out[4])
        else $error("level channel 4 active when pin idle");

    a_chan_disabled: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (!chan_enable_in[4] && chan_level_mode_in[4]) |=> !pin_irq_out[4])
        else $error("disabled channel 4 active");

    a_level_no_flag: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (chan_level_mode_in[3] && !chan_status_out[3]) |=> !chan_status_out[3])
        else $error("level channel 3 set an edge flag");

    a_level_wake: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (!pm_enable_in && chan_enable_in[4] && chan_level_mode_in[4]
         && chan_val[4] == chan_level_high_in[4]) |=> pin_wake_out)
        else $error("active level channel gave no wake request");

    a_sel_excluded: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (sel_load_in && pin_excluded_in[chan_sel_in[5*SEL_W +: SEL_W]])
        |=> $stable(s_q.sel[5*SEL_W +: SEL_W]))
        else $error("excluded pin selected on channel 5");

    a_sel_loaded: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (sel_load_in && !pin_excluded_in[chan_sel_in[SEL_W-1:0]])
        |=> (s_q.sel[SEL_W-1:0] == $past(chan_sel_in[SEL_W-1:0])))
        else $error("selection of channel 0 not loaded");

    a_sel_hold: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        !sel_load_in |=> $stable(s_q.sel))
        else $error("selection changed without a load");

    a_sync_delay: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        ##2 (s_q.sync2 == $past(pins_in, 2)))
        else $error("synchroniser depth wrong");

    a_pm_mutes_pins: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        pm_enable_in |=> (pin_irq_out == '0))
        else $error("pin request while pattern engine active");

    a_pm_no_wake: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        pm_enable_in ##1 pm_enable_in |-> !pin_wake_out)
        else $error("pattern match caused wake");

    a_term_irq: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        pm_enable_in |=> (pm_irq_out == $past(term_hit)))
        else $error("product term request missed");

    a_term_split: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (pm_enable_in && pm_term_end_in[0] && !slice_true[0]) |=> !pm_irq_out[0])
        else $error("false term 0 raised a request");

    a_event_single: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        cpu_event_notify_out |=> !cpu_event_notify_out)
        else $error("event pulse longer than one cycle");

    a_event_needs_term: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        cpu_event_notify_out |-> (pm_irq_out != '0))
        else $error("event pulse without a true term");

    a_event_masked: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        !pm_event_en_in |=> !cpu_event_notify_out)
        else $error("event pulse while events disabled");

    a_rise_detect: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        s_rise_seen(2) |-> chan_rise[2])
        else $error("transition on slice 2 missed");
endmodule

// ===== tb/pin_source_model.sv
// external pins and the cpu event listener outside the pin event block
module pin_source_model
(
    input  wire logic                          clk_sys_in,
    input  wire logic                          cpu_event_in,
    output logic [pin_event_pkg::NUM_PINS-1:0] pins_out,
    output int                                 event_count_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import pin_event_pkg::*;
    initial pins_out = '0;
    initial event_count_out = 0;
    // counts the cycles on which the cpu sees an event
    always @(posedge clk_sys_in)
        if (cpu_event_in === 1'b1)
            event_count_out <= event_count_out + 1;
    // called off the sampling edge only
    task automatic set_pin(input int idx, input logic lvl);
        pins_out[idx] = lvl;
    endtask
endmodule

// ===== tb/tb_pin_event_interrupt_logic.sv
// self-checking bench for the pin event interrupt logic
module tb_pin_event_interrupt_logic;
    timeunit 1ns;
    timeprecision 1ps;
    import pin_event_pkg::*;
    logic                      clk_sys_in = 1'b0;
    logic                      reset_in = 1'b1;
    logic [NUM_PINS-1:0]       pins, excl, ga_en, ga_pol, gb_en, gb_pol;
    logic [NUM_CHAN*SEL_W-1:0] sel;
    logic [NUM_CHAN*3-1:0]     pm_mode;
    logic [NUM_CHAN-1:0]       lvl_mode, rise_en, fall_en, lvl_high, ch_en, ch_clr, t_end;
    logic [NUM_CHAN-1:0]       pin_irq, ch_stat, pm_irq;
    logic                      sel_load, pm_en, ev_en, ga_and, ga_edge, ga_clr, gb_and;
    logic                      gb_edge, gb_clr, ev, pwake, ga_irq, gb_irq;
    logic                      ga_wake, gb_wake, ga_stat, gb_stat;
    int                        ev_cnt, ev0, m;
    int                        mismatches = 0;
    int                        compares = 0;

    always #10 clk_sys_in = ~clk_sys_in;

    pin_source_model src (.clk_sys_in(clk_sys_in), .cpu_event_in(ev), .pins_out(pins),
        .event_count_out(ev_cnt));

    pin_event_interrupt_logic dut (
        .clk_sys_in(clk_sys_in), .reset_in(reset_in), .pins_in(pins), .pin_excluded_in(excl),
        .chan_sel_in(sel), .sel_load_in(sel_load), .chan_level_mode_in(lvl_mode),
        .chan_rise_en_in(rise_en), .chan_fall_en_in(fall_en), .chan_level_high_in(lvl_high),
        .chan_enable_in(ch_en), .chan_clear_in(ch_clr), .pm_enable_in(pm_en),
        .pm_src_mode_in(pm_mode), .pm_term_end_in(t_end), .pm_event_en_in(ev_en),
        .grp_a_enable_in(ga_en), .grp_a_pol_high_in(ga_pol), .grp_a_and_in(ga_and),
        .grp_a_edge_in(ga_edge), .grp_a_clear_in(ga_clr), .grp_b_enable_in(gb_en),
        .grp_b_pol_high_in(gb_pol), .grp_b_and_in(gb_and), .grp_b_edge_in(gb_edge),
        .grp_b_clear_in(gb_clr), .pin_irq_out(pin_irq), .chan_status_out(ch_stat),
        .pm_irq_out(pm_irq), .cpu_event_notify_out(ev), .pin_wake_out(pwake),
        .group_irq_block_a_out(ga_irq), .group_irq_block_b_out(gb_irq),
        .group_irq_block_a_wake_out(ga_wake), .group_irq_block_b_wake_out(gb_wake),
        .group_a_status_out(ga_stat), .group_b_status_out(gb_stat));

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask

    task automatic pin(input int idx, input logic lvl, input int n);
        src.set_pin(idx, lvl);
        tick(n);
    endtask

    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // cuts a hang short, far beyond the fewer than a hundred cycles of the tests
    initial
    begin
        #40000;
        mismatches++;
        give_verdict();
    end

    initial
    begin
        {excl, ga_en, ga_pol, gb_en, gb_pol, sel, pm_mode} = '0;
        {lvl_mode, rise_en, fall_en, lvl_high, ch_en, ch_clr, t_end} = '0;
        {sel_load, pm_en, ev_en, ga_and, ga_edge, ga_clr, gb_and, gb_edge, gb_clr} = '0;
        excl[63:62] = 2'h3;
        tick(2);
        check("outputs in reset", {pin_irq, ch_stat, pm_irq, ev, pwake, ga_irq, gb_irq}, '0);
        reset_in = 1'b0;
        $display("test reset done");
        // channels 0..5 watch pins 3..8
        for (m = 0; m < 6; m++)
            sel[m*SEL_W +: SEL_W] = SEL_W'(m + 3);
        sel_load = 1'b1;
        tick(1);
        sel[5*SEL_W +: SEL_W] = 6'h3E;
        tick(1);
        sel_load = 1'b0;
        lvl_mode = 8'h38;
        rise_en = 8'h05;
        fall_en = 8'h06;
        lvl_high = 8'h28;
        ch_en = 8'h2F;
        pin(3, 1'b1, 2);
        check("sync latency", pin_irq, 8'h00);
        tick(1);
        check("rise ch0", {pin_irq, ch_stat[0], pwake}, {8'h01, 2'h3});
        tick(1);
        check("pin wake", pwake, 1'b1);
        ch_en = 8'h3F;
        tick(2);
        check("level low", pin_irq, 8'h11);
        pin(4, 1'b1, 3);
        check("fall only on rise", pin_irq, 8'h11);
        pin(4, 1'b0, 3);
        check("fall ch1", pin_irq, 8'h13);
        pin(5, 1'b1, 3);
        check("both ch2 rise", pin_irq, 8'h17);
        ch_clr = 8'h07;
        tick(1);
        ch_clr = 8'h00;
        check("clear flags", {pin_irq, ch_stat[2:0]}, {8'h10, 3'h0});
        pin(5, 1'b0, 3);
        check("both ch2 fall", pin_irq, 8'h14);
        src.set_pin(7, 1'b1);
        pin(6, 1'b1, 3);
        check("level high and low", pin_irq, 8'h0C);
        pin(62, 1'b1, 3);
        check("excluded pin", pin_irq, 8'h0C);
        pin(8, 1'b1, 3);
        check("kept selection", pin_irq, 8'h2C);
        for (m = 3; m < 9; m += 3)
            src.set_pin(m, 1'b0);
        src.set_pin(8, 1'b0);
        pin(62, 1'b0, 3);
        ch_clr = 8'hFF;
        tick(1);
        ch_clr = 8'h00;
        check("all idle", pin_irq, 8'h00);
        tick(1);
        check("wake idle", pwake, 1'b0);
        $display("test pin channels done");
        pm_mode = {{6{PM_NEVER}}, PM_LOW, PM_HIGH};
        t_end = 8'h82;
        pm_en = 1'b1;
        ev_en = 1'b1;
        tick(2);
        ev0 = ev_cnt;
        pin(3, 1'b1, 3);
        check("term true", {pm_irq, pin_irq}, {8'h02, 8'h00});
        tick(2);
        check("event pulse", ev_cnt - ev0, 1);
        check("no pattern wake", pwake, 1'b0);
        pin(4, 1'b1, 3);
        check("term false", pm_irq, 8'h00);
        t_end = 8'h81;
        ev_en = 1'b0;
        ev0 = ev_cnt;
        for (m = 0; m < 8; m++)
        begin
            pm_mode[2:0] = m[2:0];
            tick(2);
            check("static mode", pm_irq[0], m < 2);
        end
        check("event masked", ev_cnt - ev0, 0);
        pm_mode[2:0] = PM_RISE;
        pin(3, 1'b0, 3);
        pin(3, 1'b1, 3);
        check("rise term", pm_irq[0], 1'b1);
        tick(1);
        check("rise term ends", pm_irq[0], 1'b0);
        pm_en = 1'b0;
        $display("test pattern done");
        ga_en[11:10] = 2'h3;
        ga_pol[11:10] = 2'h3;
        src.set_pin(12, 1'b1);
        #1;
        check("disabled pin", ga_wake, 1'b0);
        tick(1);
        src.set_pin(10, 1'b1);
        #1;
        check("async wake", {ga_wake, ga_irq}, 2'h2);
        tick(3);
        check("or level irq", {ga_irq, ga_stat, gb_irq}, 3'h6);
        pin(10, 1'b0, 3);
        ga_clr = 1'b1;
        tick(1);
        ga_clr = 1'b0;
        check("group clear", {ga_irq, ga_stat}, 2'h0);
        gb_en[21:20] = 2'h3;
        gb_pol[20] = 1'b1;
        gb_and = 1'b1;
        gb_edge = 1'b1;
        tick(3);
        check("and partial", {gb_wake, gb_irq}, 2'h0);
        pin(20, 1'b1, 3);
        check("and polarity", {gb_wake, gb_irq, ga_irq}, 3'h6);
        gb_clr = 1'b1;
        tick(1);
        gb_clr = 1'b0;
        check("edge clear", gb_irq, 1'b0);
        tick(3);
        check("no new edge", gb_irq, 1'b0);
        pin(21, 1'b1, 3);
        pin(21, 1'b0, 3);
        check("new match", {gb_irq, gb_stat}, 2'h3);
        $display("test group done");
        give_verdict();
    end
endmodule
